// ==== inc/timing_scaler_pkg.sv ====
// constants and shared types of the redundant timing scaler
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Interrogate trains for the torque electronics repeat at 4.8 kpps, switch trains at 9.6 kpps.
// - Suspension supplies get a 115.2 kpps clock train and 9.6 kpps sync.
// - The 9.6 kpps pulse marks the rising zero crossing of the 9600 Hz waveform.
// - One 38.4 kpps train clocks and synchronises every dc supply.
// - Wheel supplies get the 9.6 kpps sync plus a 200 pps sync train.
// - The 9.6 kpps pulse is the reference that closes each interrogate/switch check.
// - The 200 pps train is also offered to the computer as timing reference.
// - Outputs drive redundant buses A and B; parallel scaler drivers combine as OR.
// - Each driver output enables the next divider stage, so driver faults stall the chain.
// - Every sync pulse is about 400 ns wide.
// - Main chain counts down to 200 pps through 38.4 kpps and 9.6 kpps stages.
// - 200 pps feeds over and under monitors; stuck enables speed up or stop it.
// - The 115.2 kpps subscaler runs in step with the main chain, own monitors.
// - All monitor faults of one scaler are ORed into its single fault.
// - Driver failures seen on the feedback line move control to the backup scaler.
// - Sequence rise, switch, fall, switch, sync yields 4800 Hz; breaks starve it.
// - A shared set-reset flop picks one scaler; exactly one is inhibited.
// - A fault on the active scaler flips the flop to the other scaler if that one has no fault.
// - External commands may force the selection or block automatic transfer.
// - The 3.6864 MHz clock driver goes on both coax lines with the same tests.
// - Over flags pulses faster than the one-shot; under flags pulses slower.
package timing_scaler_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int MASTER_HZ = 3_686_400;
  localparam int NCO_GCD = 3200;
  localparam int NCO_MOD = CLK_HZ / NCO_GCD;
  localparam int NCO_STEP = 2 * MASTER_HZ / NCO_GCD;
  localparam int NCO_W = 15;

  localparam int DIV_SUB = 32;
  localparam int DIV_38K = 96;
  localparam int DIV_9K6 = 4;
  localparam int DIV_200 = 48;
  localparam int RATE_SUB = 115_200;
  localparam int RATE_SEQ = 4800;

  localparam int PULSE_NS = 400;
  localparam int PULSE_CYC = PULSE_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int HOLD_W = 5;

  localparam int OVER_NUM = 3;
  localparam int OVER_DEN = 4;
  localparam int UNDER_NUM = 3;
  localparam int UNDER_DEN = 2;

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_INJECT = 4'h8;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] INJECT_RST = 16'h0000;
  localparam logic ACTIVE_RST = 1'h0;
  localparam int INJ_SCALER1 = 8;
  localparam int INJ_STUCK = 7;
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_FAULT = 1;
  localparam int STAT_FLAGS0 = 8;
  localparam int STAT_FLAGS1 = 16;

  // driver slots; the first five are stretched pulses
  localparam int D_SW = 0;
  localparam int D_200 = 1;
  localparam int D_9K6 = 2;
  localparam int D_38K = 3;
  localparam int D_SUB = 4;
  localparam int D_INTG = 5;
  localparam int D_CLK = 6;
  localparam int NPULSE = 5;

  typedef struct packed {
    logic clk_out;
    logic interrogate;
    logic sub_clock;
    logic sync_38k;
    logic sync_9k6;
    logic sync_200;
    logic switch_pulse;
  } sync_bus_type;

  typedef struct packed {
    logic seq_under;
    logic seq_over;
    logic sub_under;
    logic sub_over;
    logic main_under;
    logic main_over;
  } test_flags_type;

  typedef struct packed {
    logic auto_off;
    logic force_sel;
    logic force_en;
  } ctrl_type;

  typedef enum logic [2:0] {SEQ_RISE, SEQ_SW1, SEQ_FALL, SEQ_SW2, SEQ_SYNC} seq_state_type;

endpackage

// ==== src/rate_monitor.sv ====
// retriggerable one-shot rate monitor with over and under frequency flags
`timescale 1ns/10ps
module rate_monitor #(
  parameter int PERIOD_CYC = 434
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rstn_i, // asynchronous reset, active low
  input wire logic pulse_i, // one event of the watched train
  output logic overfrequency_fault_o, // pulses came too close
  output logic underfrequency_fault_o // pulses too far apart or missing
);
  localparam int OVER_LIM = PERIOD_CYC * timing_scaler_pkg::OVER_NUM / timing_scaler_pkg::OVER_DEN;
  localparam int UNDER_LIM = PERIOD_CYC * timing_scaler_pkg::UNDER_NUM / timing_scaler_pkg::UNDER_DEN;
  localparam int CW = $clog2(UNDER_LIM + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic over;
    logic under;
  } mon_type;

  mon_type st;
  mon_type next_st;

  always_comb
  begin
    next_st = st;
    if (pulse_i)
    begin
      next_st.over = st.cnt < CW'(OVER_LIM);
      next_st.under = 1'h0;
      next_st.cnt = '0;
    end
    else if (st.cnt != CW'(UNDER_LIM))
      next_st.cnt = CW'(st.cnt + 1'h1);
    else
      next_st.under = 1'h1;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign overfrequency_fault_o = st.over;
  assign underfrequency_fault_o = st.under;

  a_over_early: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pulse_i && st.cnt < CW'(OVER_LIM) |=> overfrequency_fault_o && !underfrequency_fault_o)
    else $error("early pulse did not raise the overfrequency flag");

  a_under_late: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    st.cnt == CW'(UNDER_LIM - 1) && !pulse_i ##1 !pulse_i |=> underfrequency_fault_o)
    else $error("missing pulse did not raise the underfrequency flag");

endmodule

// ==== src/redundant_timing_scaler.sv ====
// dual redundant timing scaler with self test, transfer and avalon registers
`timescale 1ns/10ps
module redundant_timing_scaler #(
  parameter int MAIN_DIV = timing_scaler_pkg::DIV_200,
  parameter int SEQ_PERIOD_CYC = timing_scaler_pkg::CLK_HZ / timing_scaler_pkg::RATE_SEQ
) (
  input wire logic clk_sys_i, // system clock, 50 MHz
  input wire logic rstn_i, // asynchronous reset, active low
  input wire logic [3:0] avs_address_i, // register byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // write byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall of the current request
  output timing_scaler_pkg::sync_bus_type bus_a_o, // redundant bus a
  output timing_scaler_pkg::sync_bus_type bus_b_o, // redundant bus b
  output logic computer_tick_o, // 200 pps reference to the computer
  output logic [1:0] inhibit_o, // per scaler inhibit from transfer flop
  output logic [1:0] fault_o // per scaler combined fault
);
  localparam int MASTER_PER_MAIN = timing_scaler_pkg::DIV_38K * timing_scaler_pkg::DIV_9K6 * MAIN_DIV;
  localparam int MAIN_PERIOD_CYC = timing_scaler_pkg::CLK_HZ / (timing_scaler_pkg::MASTER_HZ / MASTER_PER_MAIN);
  localparam int SUB_PERIOD_CYC = timing_scaler_pkg::CLK_HZ / timing_scaler_pkg::RATE_SUB;
  localparam int NW = timing_scaler_pkg::NCO_W;
  localparam int HW = timing_scaler_pkg::HOLD_W;
  localparam logic [HW-1:0] HOLD_MAX = HW'(timing_scaler_pkg::PULSE_CYC);

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [4:0] sub_cnt;
    logic [6:0] c38;
    logic [1:0] c96;
    logic half;
    logic [5:0] c200;
    logic intg;
    logic [timing_scaler_pkg::NPULSE-1:0][HW-1:0] hold;
  } chan_type;

  typedef struct packed {
    logic [NW-1:0] acc;
    logic clk_lvl;
    logic tick;
    chan_type [1:0] ch;
    logic active;
    logic [1:0] fault;
    timing_scaler_pkg::ctrl_type ctrl;
    logic [15:0] inject;
    logic ack;
    logic [31:0] rdata;
    logic [6:0] bus;
  } top_type;

  top_type st;
  top_type next_st;

  logic [1:0][6:0] drv;
  logic [1:0][6:0] fb;
  logic [1:0][6:0] kill;
  logic [1:0] stuck;
  logic [1:0][timing_scaler_pkg::NPULSE-1:0] start;
  logic [1:0] seq_done;
  logic [1:0] fault;
  timing_scaler_pkg::test_flags_type [1:0] flags;

  ////////////////////////////////////////////////////////////////////////////////
  // per scaler drivers, feedback and test sections

  for (genvar s = 0; s < 2; s++)
  begin : g_scaler
    assign kill[s] = st.inject[s * timing_scaler_pkg::INJ_SCALER1 +: 7];
    assign stuck[s] = st.inject[s * timing_scaler_pkg::INJ_SCALER1 + timing_scaler_pkg::INJ_STUCK];

    for (genvar k = 0; k < timing_scaler_pkg::NPULSE; k++)
    begin : g_pulse
      assign drv[s][k] = st.ch[s].hold[k] != '0;
      assign start[s][k] = (st.ch[s].hold[k] == HOLD_MAX) & ~kill[s][k];
    end

    assign drv[s][timing_scaler_pkg::D_INTG] = st.ch[s].intg;
    assign drv[s][timing_scaler_pkg::D_CLK] = st.clk_lvl;
    assign fb[s] = drv[s] & ~kill[s];

    rate_monitor #(
      .PERIOD_CYC(MAIN_PERIOD_CYC)
    ) u_main_mon (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .pulse_i(start[s][timing_scaler_pkg::D_200]),
      .overfrequency_fault_o(flags[s].main_over),
      .underfrequency_fault_o(flags[s].main_under)
    );

    rate_monitor #(
      .PERIOD_CYC(SUB_PERIOD_CYC)
    ) u_sub_mon (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .pulse_i(start[s][timing_scaler_pkg::D_SUB]),
      .overfrequency_fault_o(flags[s].sub_over),
      .underfrequency_fault_o(flags[s].sub_under)
    );

    sequence_checker u_seq (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .intg_i(fb[s][timing_scaler_pkg::D_INTG]),
      .sw_i(fb[s][timing_scaler_pkg::D_SW]),
      .sync_i(start[s][timing_scaler_pkg::D_9K6]),
      .done_o(seq_done[s])
    );

    rate_monitor #(
      .PERIOD_CYC(SEQ_PERIOD_CYC)
    ) u_seq_mon (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .pulse_i(seq_done[s]),
      .overfrequency_fault_o(flags[s].seq_over),
      .underfrequency_fault_o(flags[s].seq_under)
    );

    assign fault[s] = |flags[s];

    a_pulse_width: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(drv[s][timing_scaler_pkg::D_38K])
      |-> ##19 drv[s][timing_scaler_pkg::D_38K] ##1 !drv[s][timing_scaler_pkg::D_38K])
      else $error("sync pulse is not 20 cycles wide");

    // a 9.6 kpps pulse loaded just before the kill still steps the last stage once
    a_chain_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      kill[s][timing_scaler_pkg::D_38K] && !start[s][timing_scaler_pkg::D_9K6]
      |=> $stable(st.ch[s].c96) && $stable(st.ch[s].c200))
      else $error("stage advanced behind a dead driver");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [NW:0] sum;
    logic wrap;
    logic tk;
    logic ev38;
    logic en200;
    logic [timing_scaler_pkg::NPULSE-1:0] ev;
    logic [31:0] rd;
    sum = '0;
    wrap = 1'h0;
    tk = 1'h0;
    ev38 = 1'h0;
    en200 = 1'h0;
    ev = '0;
    rd = '0;
    next_st = st;

    // 7.3728 MHz edge rate from an exact fractional accumulator
    sum = (NW + 1)'(st.acc) + (NW + 1)'(timing_scaler_pkg::NCO_STEP);
    wrap = sum >= (NW + 1)'(timing_scaler_pkg::NCO_MOD);
    next_st.acc = wrap ? NW'(sum - (NW + 1)'(timing_scaler_pkg::NCO_MOD)) : NW'(sum);
    next_st.clk_lvl = st.clk_lvl ^ wrap;
    next_st.tick = wrap & ~st.clk_lvl;

    for (int s = 0; s < 2; s++)
    begin
      ev = '0;
      tk = st.tick & ~kill[s][timing_scaler_pkg::D_CLK];

      if (tk)
      begin
        // subscaler in step with the main chain
        ev[timing_scaler_pkg::D_SUB] = st.ch[s].sub_cnt == 5'(timing_scaler_pkg::DIV_SUB - 1);
        next_st.ch[s].sub_cnt = ev[timing_scaler_pkg::D_SUB] ? 5'h00 : 5'(st.ch[s].sub_cnt + 1'h1);
        ev38 = st.ch[s].c38 == 7'(timing_scaler_pkg::DIV_38K - 1);
        next_st.ch[s].c38 = ev38 ? 7'h00 : 7'(st.ch[s].c38 + 1'h1);
        ev[timing_scaler_pkg::D_38K] = ev38;
      end

      if (start[s][timing_scaler_pkg::D_38K])
      begin
        ev[timing_scaler_pkg::D_9K6] = st.ch[s].c96 == 2'(timing_scaler_pkg::DIV_9K6 - 1);
        next_st.ch[s].c96 = 2'(st.ch[s].c96 + 1'h1);
        ev[timing_scaler_pkg::D_SW] = st.ch[s].c96 == 2'h1;
        if (st.ch[s].c96 == 2'h0)
          next_st.ch[s].intg = ~st.ch[s].half;
      end

      if (start[s][timing_scaler_pkg::D_9K6])
        next_st.ch[s].half = ~st.ch[s].half;

      // a stuck enable on the last stage makes it count every 38.4 kpps pulse
      en200 = start[s][timing_scaler_pkg::D_9K6] | (stuck[s] & start[s][timing_scaler_pkg::D_38K]);
      if (en200)
      begin
        ev[timing_scaler_pkg::D_200] = st.ch[s].c200 >= 6'(MAIN_DIV - 1);
        next_st.ch[s].c200 = ev[timing_scaler_pkg::D_200] ? 6'h00 : 6'(st.ch[s].c200 + 1'h1);
      end

      for (int k = 0; k < timing_scaler_pkg::NPULSE; k++)
      begin
        if (ev[k])
          next_st.ch[s].hold[k] = HOLD_MAX;
        else if (st.ch[s].hold[k] != '0)
          next_st.ch[s].hold[k] = HW'(st.ch[s].hold[k] - 1'h1);
      end
    end

    // shared transfer flop
    next_st.fault = fault;
    if (st.ctrl.force_en)
      next_st.active = st.ctrl.force_sel;
    else if (!st.ctrl.auto_off && fault[st.active] && !fault[~st.active])
      next_st.active = ~st.active;

    // only the enabled scaler reaches the bus; the lines wire-or
    next_st.bus = (fb[0] & {7{~st.active}}) | (fb[1] & {7{st.active}});

    // register slave, one wait state on every access
    next_st.ack = (avs_read_i | avs_write_i) & ~st.ack;
    case (avs_address_i)
      timing_scaler_pkg::OFS_CTRL:
        rd[2:0] = st.ctrl;
      timing_scaler_pkg::OFS_STATUS:
      begin
        rd[timing_scaler_pkg::STAT_ACTIVE] = st.active;
        rd[timing_scaler_pkg::STAT_FAULT +: 2] = st.fault;
        rd[timing_scaler_pkg::STAT_FLAGS0 +: 6] = flags[0];
        rd[timing_scaler_pkg::STAT_FLAGS1 +: 6] = flags[1];
      end
      timing_scaler_pkg::OFS_INJECT:
        rd[15:0] = st.inject;
      default:
        rd = '0;
    endcase
    if (avs_read_i && !st.ack)
      next_st.rdata = rd;

    if (avs_write_i && st.ack)
    begin
      case (avs_address_i)
        timing_scaler_pkg::OFS_CTRL:
          if (avs_byteenable_i[0])
            next_st.ctrl = timing_scaler_pkg::ctrl_type'(avs_writedata_i[2:0]);
        timing_scaler_pkg::OFS_INJECT:
        begin
          if (avs_byteenable_i[0])
            next_st.inject[7:0] = avs_writedata_i[7:0];
          if (avs_byteenable_i[1])
            next_st.inject[15:8] = avs_writedata_i[15:8];
        end
        default:
          next_st.ack = 1'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;
      st.ctrl <= timing_scaler_pkg::CTRL_RST;
      st.inject <= timing_scaler_pkg::INJECT_RST;
      st.active <= timing_scaler_pkg::ACTIVE_RST;
    end
    else
      st <= next_st;
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st.ack;
  assign avs_readdata_o = st.rdata;
  assign bus_a_o = timing_scaler_pkg::sync_bus_type'(st.bus);
  assign bus_b_o = timing_scaler_pkg::sync_bus_type'(st.bus);
  assign computer_tick_o = st.bus[timing_scaler_pkg::D_200];
  assign inhibit_o = st.active ? 2'h1 : 2'h2;
  assign fault_o = st.fault;

  ////////////////////////////////////////////////////////////////////////////////

  a_nco_spacing: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    st.tick |=> (!st.tick) [*8])
    else $error("master ticks closer than the 3.6864 MHz spacing");

  a_bus_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    st.active && fb[1][timing_scaler_pkg::D_38K] |=> bus_a_o.sync_38k && bus_b_o.sync_38k)
    else $error("active scaler pulse missing on a bus");

  a_auto_transfer: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !st.ctrl.force_en && !st.ctrl.auto_off && fault[st.active] && !fault[~st.active]
    |=> st.active != $past(st.active))
    else $error("faulty active scaler was not replaced");

  a_force_select: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    st.ctrl.force_en |=> st.active == $past(st.ctrl.force_sel) && inhibit_o[$past(st.ctrl.force_sel)] == 1'h0)
    else $error("forced selection not obeyed");

endmodule

// ==== src/sequence_checker.sv ====
// interrogate and switch order checker, one pulse per good sequence
`timescale 1ns/10ps
module sequence_checker (
  input wire logic clk_sys_i, // system clock
  input wire logic rstn_i, // asynchronous reset, active low
  input wire logic intg_i, // interrogate feedback level
  input wire logic sw_i, // switch feedback pulse
  input wire logic sync_i, // 9.6 kpps reference event
  output logic done_o // one cycle per complete sequence
);
  typedef struct packed {
    timing_scaler_pkg::seq_state_type state;
    logic intg_d;
    logic sw_d;
    logic done;
  } chk_type;

  chk_type st;
  chk_type next_st;
  logic rise;
  logic fall;
  logic sw;

  assign rise = intg_i & ~st.intg_d;
  assign fall = ~intg_i & st.intg_d;
  assign sw = sw_i & ~st.sw_d;

  // any interrogate edge or switch out of its place restarts the search at the rising edge; an early sync is ignored
  always_comb
  begin
    next_st = st;
    next_st.intg_d = intg_i;
    next_st.sw_d = sw_i;
    next_st.done = 1'h0;
    unique case (st.state)
      timing_scaler_pkg::SEQ_RISE:
        if (rise)
          next_st.state = timing_scaler_pkg::SEQ_SW1;
      timing_scaler_pkg::SEQ_SW1:
        if (sw)
          next_st.state = timing_scaler_pkg::SEQ_FALL;
        else if (fall)
          next_st.state = timing_scaler_pkg::SEQ_RISE;
      timing_scaler_pkg::SEQ_FALL:
        if (fall)
          next_st.state = timing_scaler_pkg::SEQ_SW2;
        else if (sw || rise)
          next_st.state = timing_scaler_pkg::SEQ_RISE;
      timing_scaler_pkg::SEQ_SW2:
        if (sw)
          next_st.state = timing_scaler_pkg::SEQ_SYNC;
        else if (rise || fall)
          next_st.state = timing_scaler_pkg::SEQ_RISE;
      timing_scaler_pkg::SEQ_SYNC:
        if (sync_i)
        begin
          next_st.state = timing_scaler_pkg::SEQ_RISE;
          next_st.done = 1'h1;
        end
        else if (rise || fall || sw)
          next_st.state = timing_scaler_pkg::SEQ_RISE;
      default:
        next_st.state = timing_scaler_pkg::SEQ_RISE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign done_o = st.done;

  a_seq_done: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    st.state == timing_scaler_pkg::SEQ_SYNC && sync_i |=> done_o ##1 !done_o)
    else $error("completed sequence gave no single done pulse");

  a_seq_break: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    st.state == timing_scaler_pkg::SEQ_FALL && !fall && (sw || rise)
    |=> st.state == timing_scaler_pkg::SEQ_RISE && !done_o)
    else $error("out of order switch did not restart the check");

endmodule

// ==== tb/redundant_timing_scaler_tb.sv ====
// self-checking bench of the redundant timing scaler
`timescale 1ns/10ps
module redundant_timing_scaler_tb;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  timing_scaler_pkg::sync_bus_type bus_a_o;
  timing_scaler_pkg::sync_bus_type bus_b_o;
  logic computer_tick_o;
  logic [1:0] inhibit_o;
  logic [1:0] fault_o;
  logic [31:0] width [7];
  logic [31:0] period [7];
  logic [31:0] q;
  logic [2:0] ctrl;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'h3E96;
  int tk [7] = '{384, 768, 384, 96, 32, 768, 1};

  initial
    forever #10 clk_sys_i = ~clk_sys_i;

  redundant_timing_scaler #(.MAIN_DIV(2)) u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .bus_a_o(bus_a_o), .bus_b_o(bus_b_o),
    .computer_tick_o(computer_tick_o), .inhibit_o(inhibit_o), .fault_o(fault_o));

  sync_consumer u_far (.clk_sys_i(clk_sys_i), .bus_a_i(bus_a_o), .bus_b_i(bus_b_o),
    .width_o(width), .period_o(period));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    // waitrequest and read data are taken as they stand at the rising edge
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    check(n >= 50, 1'b0);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wait_fault(input int s, input int lim);
    int n;
    n = 0;
    while (fault_o[s] !== 1'b1 && n < lim)
    begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask

  function automatic int exp_cyc(input int ticks);
    return int'(longint'(ticks) * timing_scaler_pkg::CLK_HZ / timing_scaler_pkg::MASTER_HZ);
  endfunction

  // master clock comes from an nco, so two cycles of jitter either way are fair
  function automatic logic [31:0] near(input logic [31:0] seen, input int ticks);
    int e;
    e = exp_cyc(ticks);
    return (int'(seen) >= e - 2 && int'(seen) <= e + 2) ? e : seen;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys_i)
  begin
    check(bus_b_o, bus_a_o);
    check(computer_tick_o, bus_a_o.sync_200);
    check(inhibit_o[0] ^ inhibit_o[1], 1'b1);
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(negedge clk_sys_i);
    check(inhibit_o, 2'b10);
    check(fault_o, 2'b00);
    foreach (tk[i])
    begin
      bus(1'b0, 4'(i * 4), 32'h0, q);
      if (i != 1)
        check(q, 32'h0);
    end
    repeat (8)
    begin
      ctrl = 3'($random(seed));
      bus(1'b1, 4'h0, {29'h0, ctrl}, q);
      bus(1'b0, 4'h0, 32'h0, q);
      check(q, {29'h0, ctrl});
      if (ctrl[0])
        check(inhibit_o, ctrl[1] ? 2'b01 : 2'b10);
    end
    bus(1'b1, 4'h0, 32'h0, q);
    bus(1'b1, 4'hC, 32'h7, q);
    bus(1'b1, 4'h4, 32'hFFFFFFFF, q);
    bus(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    check(q[0], inhibit_o[0]);
    repeat (25000) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    for (int i = 0; i < 7; i++)
    begin
      check(near(period[i], tk[i]), exp_cyc(tk[i]));
      if (i < 5)
        check(width[i], timing_scaler_pkg::PULSE_CYC);
    end
    check(near(width[5], 384), exp_cyc(384));
    // put scaler 0 in control so that its fault must move control away
    bus(1'b1, 4'h0, 32'h1, q);
    bus(1'b1, 4'h0, 32'h0, q);
    bus(1'b1, 4'h8, 32'h80, q);
    wait_fault(0, 30000);
    check(fault_o[0], 1'b1);
    repeat (5) @(negedge clk_sys_i);
    check(inhibit_o, 2'b01);
    bus(1'b0, 4'h4, 32'h0, q);
    check({q[8], q[1], q[0]}, 3'b111);
    bus(1'b1, 4'h8, 32'h0, q);
    bus(1'b1, 4'h0, 32'h1, q);
    repeat (4) @(negedge clk_sys_i);
    check(inhibit_o, 2'b10);
    bus(1'b1, 4'h8, 32'h800, q);
    wait_fault(1, 30000);
    check(fault_o[1], 1'b1);
    check(inhibit_o, 2'b10);
    bus(1'b1, 4'h8, 32'h0, q);
    bus(1'b1, 4'h0, 32'h0, q);
    end_sim();
  end
endmodule

// ==== tb/sync_consumer.sv ====
// model of the supplies and computer that take the redundant sync buses
`timescale 1ns/10ps
module sync_consumer (
  input wire logic clk_sys_i, // system clock
  input wire timing_scaler_pkg::sync_bus_type bus_a_i, // redundant bus a
  input wire timing_scaler_pkg::sync_bus_type bus_b_i, // redundant bus b
  output logic [31:0] width_o [7], // last high time per line, cycles
  output logic [31:0] period_o [7] // last rise to rise time per line, cycles
);
  timing_scaler_pkg::sync_bus_type seen;
  logic [6:0] prev = 7'h00;
  logic [31:0] hi [7] = '{default: 0};
  logic [31:0] since [7] = '{default: 0};

  // diode isolated receivers see both buses as one wired or
  assign seen = bus_a_i | bus_b_i;

  always @(posedge clk_sys_i)
  begin
    prev <= seen;
    for (int i = 0; i < 7; i++)
    begin
      since[i] <= since[i] + 1;
      if (seen[i])
        hi[i] <= hi[i] + 1;
      if (seen[i] && !prev[i])
      begin
        period_o[i] <= since[i];
        since[i] <= 1;
        hi[i] <= 1;
      end
      if (!seen[i] && prev[i])
        width_o[i] <= hi[i];
    end
  end
endmodule
